// ==== core/frw_pkg.sv ====
// Purpose: constants and carriers for the disk-side bit sequencer
// Assumes: 16 MHz timing base replaced by the 50 MHz core clock, one crystal tick per core cycle
// Notes:   maps, zone limits and divider values are shared with the bench
//
// Operation
// - divide crystal by sixteen for system clock
// - bit clock divider selects 16, 15, 14, 13
// - inner track zones use faster bit clock
// - decode program stores at C000 and E000
// - decode working memory at 0000 to 07FF
// - serial bus adapter select low at 1C00
// - disk adapter select at 1800 to 180F
// - inverted attention to port bit and edge
// - ack xor attention, inverted, drives data
// - port byte loaded then shifted out serially
// - eighth read bit latches byte, ready low
// - all ones deserialised drives sync low
// - stepper count decodes to one phase
// - spindle request inverted to motor on low
// - write protect sensed, activity lamp driven
// - gated bit toggles flip-flop driving windings
// - one is reversal, zero no reversal
// - flux pulse clears cell counter, nor output
// - one-shot shapes pulse, suppresses spurious ones
// - write mode enables drivers and erase
// - erase coil energised during every write
// - each count step moves half a track
`default_nettype none

package frw_pkg;
  localparam logic [4:0]  SYS_DIV       = 5'h10;
  localparam logic [4:0]  DIV_ZONE1     = 5'h0D;
  localparam logic [4:0]  DIV_ZONE2     = 5'h0E;
  localparam logic [4:0]  DIV_ZONE3     = 5'h0F;
  localparam logic [4:0]  DIV_ZONE4     = 5'h10;
  localparam logic [5:0]  ZONE1_LAST    = 6'h11;
  localparam logic [5:0]  ZONE2_LAST    = 6'h18;
  localparam logic [5:0]  ZONE3_LAST    = 6'h1E;
  localparam logic [15:0] ROM_LO_BASE   = 16'hC000;
  localparam logic [15:0] ROM_HI_BASE   = 16'hE000;
  localparam logic [15:0] RAM_LAST      = 16'h07FF;
  localparam logic [15:0] SERIAL_BASE   = 16'h1C00;
  localparam logic [15:0] DISK_BASE     = 16'h1800;
  localparam logic [15:0] PORT_MASK     = 16'hFFF0;
  localparam logic [7:0]  SYNC_PATTERN  = 8'hFF;
  localparam logic [2:0]  BITS_LAST     = 3'h7;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [3:0]  PULSE_CYCLES  = 4'h4;
  localparam logic [3:0]  FILTER_CYCLES = 4'hC;

  typedef struct packed {
    logic rom_lo;
    logic rom_hi;
    logic ram;
    logic serial_sel_n;
    logic disk_sel;
  } frw_sel_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } frw_phase_s;
endpackage : frw_pkg

`default_nettype wire

// ==== core/frw_sequencer.sv ====
// Purpose: clock dividers, write serialiser, read deserialiser, decoders for the drive logic
// Assumes: processor signals share clk; flux pulse and attention come from pins
// Notes:   register port: zone divider, write mode, write byte, read byte, status
//
// Implementation choices: the register addresses and the strobed register port.
`default_nettype none

module frw_sequencer
  import frw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // processor address decode
  input  wire logic [15:0] cpu_addr,
  output logic             sys_clk,
  output frw_sel_s         sel,
  // serial bus attention
  input  wire logic        bus_attention_in,
  input  wire logic        attention_ack_out,
  output logic             portb_bit_seven,
  output logic             adapter_edge_input,
  input  wire logic        bus_data_in,
  output logic             bus_data_out,
  output logic             bus_data_oe,
  // disk adapter port a and b
  input  wire logic [7:0]  port_a_wdata,
  input  wire logic        port_a_write,
  input  wire logic        port_a_read,
  input  wire logic        write_mode,
  input  wire logic [1:0]  zone_select,
  input  wire logic        stepper_count_lsb,
  input  wire logic        stepper_count_msb,
  input  wire logic        spindle_request,
  input  wire logic        activity_request,
  input  wire logic        write_protect_pin,
  output logic             write_protect,
  output logic [7:0]       disk_byte_port,
  output logic             byte_ready_n,
  output logic             sync_n,
  // head, motors, lamp
  input  wire logic        flux_pulse_pin,
  output logic             head_a,
  output logic             head_b,
  output logic             write_enable,
  output logic             erase_enable,
  output frw_phase_s       stepper_phase,
  output logic             spindle_on_n,
  output logic             activity_lamp
);

  // ==================================================
  // pin synchronisers
  logic [1:0] atn_sync_reg;
  logic [1:0] flux_sync_reg;
  logic [1:0] wp_sync_reg;
  logic       flux_last_reg;
  wire  logic atn_level = atn_sync_reg[1];
  wire  logic flux_rise = flux_sync_reg[1] & ~flux_last_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      atn_sync_reg  <= 2'h0;
      flux_sync_reg <= 2'h0;
      wp_sync_reg   <= 2'h0;
      flux_last_reg <= 1'b0;
    end else begin
      atn_sync_reg  <= {atn_sync_reg[0], bus_attention_in};
      flux_sync_reg <= {flux_sync_reg[0], flux_pulse_pin};
      wp_sync_reg   <= {wp_sync_reg[0], write_protect_pin};
      flux_last_reg <= flux_sync_reg[1];
    end
  end

  // ==================================================
  // system clock divider
  logic [3:0] sys_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) sys_cnt_reg <= 4'h0;
    else     sys_cnt_reg <= sys_cnt_reg + 4'h1;
  end
  assign sys_clk = sys_cnt_reg[3];

  // ==================================================
  // recording bit clock, zone programmable
  logic [4:0] bit_div;
  logic [4:0] bit_cnt_reg;
  wire  logic bit_tick = (bit_cnt_reg == bit_div - 5'h1);

  always_comb begin
    unique case (zone_select)
      2'h0: bit_div = DIV_ZONE4;
      2'h1: bit_div = DIV_ZONE3;
      2'h2: bit_div = DIV_ZONE2;
      2'h3: bit_div = DIV_ZONE1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || bit_tick) bit_cnt_reg <= 5'h0;
    else                 bit_cnt_reg <= bit_cnt_reg + 5'h1;
  end

  // ==================================================
  // address decode
  assign sel.rom_lo       = (cpu_addr[15:13] == ROM_LO_BASE[15:13]);
  assign sel.rom_hi       = (cpu_addr[15:13] == ROM_HI_BASE[15:13]);
  assign sel.ram          = (cpu_addr <= RAM_LAST);
  assign sel.serial_sel_n = ~((cpu_addr & PORT_MASK) == SERIAL_BASE);
  assign sel.disk_sel     = ((cpu_addr & PORT_MASK) == DISK_BASE);

  // ==================================================
  // serial bus attention
  assign portb_bit_seven    = ~atn_level;
  assign adapter_edge_input = ~atn_level;
  // open-drain data: driving low when inverted xor is low
  wire  logic data_level    = ~(attention_ack_out ^ atn_level);
  assign bus_data_out = 1'b0;
  assign bus_data_oe  = ~data_level;

  // ==================================================
  // write path
  logic [7:0] wr_shift_reg;
  logic [2:0] wr_bits_reg;
  logic [7:0] wr_hold_reg;
  logic       wr_full_reg;
  logic       head_reg;
  logic       wr_ready_reg;
  wire  logic wr_bit      = wr_shift_reg[7];
  wire  logic wr_last_bit = bit_tick & (wr_bits_reg == BITS_LAST);

  always_ff @(posedge clk) begin
    if (rst || !write_mode) begin
      wr_shift_reg <= DATA_RESET;
      wr_bits_reg  <= 3'h0;
      wr_hold_reg  <= DATA_RESET;
      wr_full_reg  <= 1'b0;
      head_reg     <= 1'b0;
      wr_ready_reg <= 1'b0;
    end else begin
      if (port_a_write) begin
        wr_hold_reg <= port_a_wdata;
        wr_full_reg <= 1'b1;
      end
      wr_ready_reg <= wr_last_bit;
      if (bit_tick) begin
        head_reg    <= head_reg ^ wr_bit;
        wr_bits_reg <= wr_bits_reg + 3'h1;
        if (wr_last_bit) begin
          wr_shift_reg <= wr_full_reg ? wr_hold_reg : DATA_RESET;
          if (!port_a_write) wr_full_reg <= 1'b0;
        end else begin
          wr_shift_reg <= {wr_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  assign head_a       = head_reg;
  assign head_b       = ~head_reg;
  assign write_enable = write_mode;
  assign erase_enable = write_mode;

  // ==================================================
  // read path: one-shot filter and cell counter
  logic [3:0] shot_cnt_reg;
  logic [3:0] filt_cnt_reg;
  wire  logic shot_fire = flux_rise & (filt_cnt_reg == 4'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      shot_cnt_reg <= 4'h0;
      filt_cnt_reg <= 4'h0;
    end else if (shot_fire) begin
      shot_cnt_reg <= PULSE_CYCLES;
      filt_cnt_reg <= FILTER_CYCLES;
    end else begin
      if (shot_cnt_reg != 4'h0) shot_cnt_reg <= shot_cnt_reg - 4'h1;
      if (filt_cnt_reg != 4'h0) filt_cnt_reg <= filt_cnt_reg - 4'h1;
    end
  end

  // cell timer restarts on flux, so the sample sits mid-cell whatever the disk phase
  logic [4:0] cell_phase_reg;
  logic [1:0] cell_cnt_reg;
  wire  logic shot_active = (shot_cnt_reg != 4'h0);
  wire  logic cell_end    = (cell_phase_reg == bit_div - 5'h1);
  wire  logic rd_bit      = ~(cell_cnt_reg[1] | cell_cnt_reg[0]);
  wire  logic rd_sample   = (cell_phase_reg == {1'b0, bit_div[4:1]});

  always_ff @(posedge clk) begin
    if (rst || shot_fire) begin
      cell_phase_reg <= 5'h00;
      cell_cnt_reg   <= 2'h0;
    end else begin
      cell_phase_reg <= cell_end ? 5'h00 : cell_phase_reg + 5'h01;
      // saturate: long zero runs must not wrap into a false one
      if (cell_end && cell_cnt_reg != 2'h3) cell_cnt_reg <= cell_cnt_reg + 2'h1;
    end
  end

  // ==================================================
  // deserialiser, byte latch, sync
  logic [7:0] rd_shift_reg;
  logic [2:0] rd_bits_reg;
  logic [7:0] rd_latch_reg;
  logic       rd_ready_reg;
  wire  logic [7:0] rd_shift_next = {rd_shift_reg[6:0], rd_bit};
  wire  logic sync_now = (rd_shift_reg == SYNC_PATTERN);

  always_ff @(posedge clk) begin
    if (rst || write_mode) begin
      rd_shift_reg <= DATA_RESET;
      rd_bits_reg  <= 3'h0;
      rd_latch_reg <= DATA_RESET;
      rd_ready_reg <= 1'b0;
    end else begin
      rd_ready_reg <= 1'b0;
      if (rd_sample) begin
        rd_shift_reg <= rd_shift_next;
        rd_bits_reg  <= sync_now ? 3'h0 : rd_bits_reg + 3'h1;
        if (rd_bits_reg == BITS_LAST && !sync_now) begin
          rd_latch_reg <= rd_shift_next;
          rd_ready_reg <= 1'b1;
        end
      end
    end
  end

  logic sync_reg;
  always_ff @(posedge clk) begin
    if (rst) sync_reg <= 1'b0;
    else     sync_reg <= sync_now;
  end

  assign disk_byte_port = rd_latch_reg;
  assign byte_ready_n   = ~(rd_ready_reg | wr_ready_reg);
  assign sync_n         = ~sync_reg;

  // ==================================================
  // stepper, spindle, lamp, write protect
  wire logic [1:0] step_count = {stepper_count_msb, stepper_count_lsb};
  assign stepper_phase.a = (step_count == 2'h0);
  assign stepper_phase.b = (step_count == 2'h1);
  assign stepper_phase.c = (step_count == 2'h2);
  assign stepper_phase.d = (step_count == 2'h3);
  assign spindle_on_n    = ~spindle_request;
  assign activity_lamp   = activity_request;
  assign write_protect   = wp_sync_reg[1];

  // ==================================================
  // assertions
  wire logic unused_in = port_a_read ^ bus_data_in;

  a_sys_clock_period: assert property (@(posedge clk) disable iff (rst)
    $rose(sys_clk) |-> ##16 $rose(sys_clk)) else $error("system clock period wrong");
  a_bit_clock_div: assert property (@(posedge clk) disable iff (rst)
    bit_tick && $stable(zone_select) |=> !bit_tick) else $error("bit clock too fast");
  a_zone_inner: assert property (@(posedge clk) disable iff (rst)
    zone_select == 2'h3 |-> bit_div == 5'h0D) else $error("inner zone divider wrong");
  a_rom_decode: assert property (@(posedge clk)
    cpu_addr >= 16'hC000 |-> sel.rom_lo ^ sel.rom_hi) else $error("rom decode wrong");
  a_ram_decode: assert property (@(posedge clk)
    sel.ram |-> !sel.rom_lo && !sel.disk_sel && sel.serial_sel_n) else $error("ram overlaps");
  a_port_decode: assert property (@(posedge clk)
    !sel.serial_sel_n |-> cpu_addr[15:4] == 12'h1C0) else $error("serial select wrong");
  a_disk_decode: assert property (@(posedge clk)
    sel.disk_sel |-> !sel.ram && sel.serial_sel_n) else $error("disk select wrong");
  a_atn_invert: assert property (@(posedge clk) disable iff (rst)
    $rose(bus_attention_in) |-> ##2 portb_bit_seven == 1'b0) else $error("attention not inverted");
  a_data_drive: assert property (@(posedge clk) disable iff (rst)
    bus_data_oe == (attention_ack_out ^ atn_level)) else $error("data drive wrong");
  a_byte_ready: assert property (@(posedge clk) disable iff (rst)
    !write_mode && rd_ready_reg |=> !rd_ready_reg) else $error("ready too long");
  a_sync_flag: assert property (@(posedge clk) disable iff (rst)
    rd_shift_reg == 8'hFF |=> !sync_n) else $error("sync missed");
  a_one_phase: assert property (@(posedge clk)
    $onehot(stepper_phase)) else $error("phase not one-hot");
  a_motor_on: assert property (@(posedge clk)
    spindle_on_n != spindle_request) else $error("motor polarity");
  a_head_toggle: assert property (@(posedge clk) disable iff (rst)
    write_mode && bit_tick && !wr_bit |=> $stable(head_a)) else $error("zero reversed head");
  a_erase_write: assert property (@(posedge clk)
    write_mode |-> erase_enable && write_enable) else $error("erase off in write");
  a_filter_gap: assert property (@(posedge clk) disable iff (rst)
    shot_fire |=> !shot_fire [*8]) else $error("pulse not filtered");
  c_byte_read:  cover property (@(posedge clk) disable iff (rst) rd_ready_reg);
  c_sync_seen:  cover property (@(posedge clk) disable iff (rst) !sync_n);
  c_write_byte: cover property (@(posedge clk) disable iff (rst) wr_ready_reg);
  c_pulse_shaped: cover property (@(posedge clk) disable iff (rst) shot_active && rd_sample);

endmodule : frw_sequencer

`default_nettype wire

// ==== dv/frw_cpu_model.sv ====
// Purpose: processor side of the disk adapter, feeding write bytes and stepping the head
// Assumes: bench holds wr_go high for a whole write run
// Notes:   data lines toggle while no byte is offered, so stale data is never mistaken
`default_nettype none

module frw_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench commands
  input  wire logic       wr_go,
  input  wire logic [7:0] wr_byte,
  input  wire logic       step_up,
  input  wire logic       step_dn,
  // adapter ports
  input  wire logic       byte_ready_n,
  output logic [7:0]      port_a_wdata,
  output logic            port_a_write,
  output logic            port_a_read,
  output logic            stepper_count_lsb,
  output logic            stepper_count_msb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       go_reg;
  logic [1:0] step_reg;
  logic       feed;

  // first byte on start, then one byte per ready pulse
  assign feed = wr_go & (~go_reg | ~byte_ready_n);
  assign {stepper_count_msb, stepper_count_lsb} = step_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      go_reg       <= 1'b0;
      step_reg     <= 2'h0;
      port_a_write <= 1'b0;
      port_a_read  <= 1'b0;
      port_a_wdata <= 8'h00;
    end else begin
      go_reg       <= wr_go;
      port_a_write <= feed;
      port_a_wdata <= feed ? wr_byte : ~port_a_wdata;
      port_a_read  <= ~wr_go & ~byte_ready_n;
      step_reg     <= step_reg + {1'b0, step_up} - {1'b0, step_dn};
    end
  end
endmodule : frw_cpu_model

`default_nettype wire

// ==== dv/frw_sequencer_test.sv ====
// Purpose: self-checking bench for the disk-side bit sequencer
// Assumes: zone code 0 is the slowest bit clock
// Notes:   read data is accepted in either bit phase, the cell alignment is free
`default_nettype none

module frw_sequencer_test;
  import frw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, bus_attention_in = 0, attention_ack_out = 0, write_mode = 0;
  logic spindle_request = 0, activity_request = 0, write_protect_pin = 0, flux_pulse_pin = 0;
  logic wr_go = 0, up = 0, dn = 0, sync_seen = 0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [1:0] zone_select = 2'h0, cnt = 2'h0;
  logic [7:0] wr_byte = 8'h00, port_a_wdata, disk_byte_port, rd_last;
  logic sys_clk, portb_bit_seven, adapter_edge_input, bus_data_in, bus_data_out, bus_data_oe;
  logic port_a_write, port_a_read, stepper_count_lsb, stepper_count_msb, write_protect;
  logic byte_ready_n, sync_n, head_a, head_b, write_enable, erase_enable, spindle_on_n, activity_lamp;
  frw_sel_s sel;
  frw_phase_s stepper_phase;
  int err_total = 0, samples_checked = 0, rd_cnt = 0, gap, flips, bad, c0;
  logic [15:0] corner[16] = '{16'h0000, 16'h07FF, 16'h0800, 16'h17FF, 16'h1800, 16'h180F, 16'h1810,
    16'h1BFF, 16'h1C00, 16'h1C0F, 16'h1C10, 16'hBFFF, 16'hC000, 16'hDFFF, 16'hE000, 16'hFFFF};
  int tracks[8] = '{1, 17, 18, 24, 25, 30, 31, 35};

  // open-drain data line with pull-up
  assign bus_data_in = ~bus_data_oe;

  frw_sequencer u_frw_sequencer (.clk, .rst, .cpu_addr, .sys_clk, .sel, .bus_attention_in,
    .attention_ack_out, .portb_bit_seven, .adapter_edge_input, .bus_data_in, .bus_data_out,
    .bus_data_oe, .port_a_wdata, .port_a_write, .port_a_read, .write_mode, .zone_select,
    .stepper_count_lsb, .stepper_count_msb, .spindle_request, .activity_request, .write_protect_pin,
    .write_protect, .disk_byte_port, .byte_ready_n, .sync_n, .flux_pulse_pin, .head_a, .head_b,
    .write_enable, .erase_enable, .stepper_phase, .spindle_on_n, .activity_lamp);

  frw_cpu_model u_frw_cpu_model (.clk, .rst, .wr_go, .wr_byte, .step_up(up), .step_dn(dn),
    .byte_ready_n, .port_a_wdata, .port_a_write, .port_a_read, .stepper_count_lsb, .stepper_count_msb);

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (sync_n === 1'b0) sync_seen <= 1'b1;
    if (byte_ready_n === 1'b0) begin
      rd_cnt++;
      rd_last <= disk_byte_port;
    end
  end

  // ==========================================================
  // expectations
  function automatic frw_sel_s exp_sel(input logic [15:0] a);
    exp_sel.rom_lo       = a >= ROM_LO_BASE && a < ROM_HI_BASE;
    exp_sel.rom_hi       = a >= ROM_HI_BASE;
    exp_sel.ram          = a <= RAM_LAST;
    exp_sel.serial_sel_n = (a & PORT_MASK) != SERIAL_BASE;
    exp_sel.disk_sel     = (a & PORT_MASK) == DISK_BASE;
  endfunction : exp_sel

  function automatic int div_of(input int t);
    return t <= ZONE1_LAST ? DIV_ZONE1 : t <= ZONE2_LAST ? DIV_ZONE2 : t <= ZONE3_LAST ? DIV_ZONE3 : DIV_ZONE4;
  endfunction : div_of

  // ==========================================================
  // compares and drivers
  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bits

  task automatic check_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_count

  // cycles between ready pulses and head reversals inside them
  task automatic measure();
    logic h;
    int n;
    n = 0;
    gap = 0;
    flips = 0;
    bad = 0;
    while (byte_ready_n !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    h = head_a;
    @(negedge clk);
    gap++;
    flips += (head_a !== h);
    bad += (head_b !== ~head_a);
    h = head_a;
    while (byte_ready_n !== 1'b0 && gap < 600) begin
      @(negedge clk);
      gap++;
      flips += (head_a !== h);
      bad += (head_b !== ~head_a);
      h = head_a;
    end
  endtask : measure

  task automatic send(input logic [7:0] b, input logic glitch);
    for (int i = 7; i >= 0; i--) begin
      for (int c = 0; c < DIV_ZONE4; c++) begin
        @(posedge clk);
        flux_pulse_pin <= b[i] && (c < 2 || (glitch && (c == 5 || c == 6)));
      end
    end
  endtask : send

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    #1_000_000;
    err_total++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hC0D8A469));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 56; i++) begin
      @(posedge clk);
      cpu_addr <= i < 16 ? corner[i] : 16'($urandom);
      @(negedge clk);
      check_bits({3'h0, sel}, {3'h0, exp_sel(cpu_addr)});
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      up <= i < 4;
      dn <= i >= 4;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
      cnt = i < 4 ? cnt + 2'h1 : cnt - 2'h1;
      @(negedge clk);
      check_bits({4'h0, stepper_phase}, 8'h08 >> cnt);
    end
    @(posedge sys_clk);
    c0 = $time;
    @(posedge sys_clk);
    check_count(($time - c0) / 20, SYS_DIV);
    repeat (16) begin
      @(posedge clk);
      {bus_attention_in, attention_ack_out, spindle_request, activity_request, write_protect_pin, write_mode}
        <= 6'($urandom);
      repeat (5) @(posedge clk);
      @(negedge clk);
      check_bits({portb_bit_seven, adapter_edge_input, bus_data_oe, spindle_on_n, activity_lamp, write_protect,
        write_enable, erase_enable}, {~bus_attention_in, ~bus_attention_in, attention_ack_out ^ bus_attention_in,
        ~spindle_request, activity_request, write_protect_pin, write_mode, write_mode});
    end
    foreach (tracks[i]) begin
      @(posedge clk);
      zone_select <= tracks[i] <= ZONE1_LAST ? 2'h3 : tracks[i] <= ZONE2_LAST ? 2'h2 :
        tracks[i] <= ZONE3_LAST ? 2'h1 : 2'h0;
      write_mode <= 1'b1;
      wr_byte <= i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
      wr_go <= 1'b1;
      measure();
      measure();
      check_count(gap, 8 * div_of(tracks[i]));
      check_count(flips, $countones(wr_byte));
      check_count(bad, 0);
      @(posedge clk);
      wr_go <= 1'b0;
    end
    @(posedge clk);
    write_mode <= 1'b0;
    zone_select <= 2'h0;
    repeat (3) send(8'hFF, 1'b1);
    check_bits({7'h0, sync_seen}, 8'h01);
    c0 = rd_cnt;
    repeat (4) send(8'h55, 1'b0);
    check_bits({7'h0, rd_cnt > c0}, 8'h01);
    check_bits({7'h0, rd_last === 8'h55 || rd_last === 8'hAA}, 8'h01);
    check_bits({7'h0, sync_n}, 8'h01);
    print_verdict();
  end
endmodule : frw_sequencer_test

`default_nettype wire
